// ==== uhsc_driver_model.sv ====
// Controller driver model that issues command-code accesses on the host bus.
`timescale 1ns/1ps
module uhsc_driver_model (
    input wire logic clk,
    output logic cmd_rd,
    output logic cmd_wr,
    output logic [7:0] cmd_code,
    output logic [31:0] cmd_wdata
);
    logic [31:0] exp_q[$];
    initial begin
        cmd_rd = 1'b0;
        cmd_wr = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 32'h0000_0000;
    end
    ////////////////////////////////////////
    // Released code and data lines show the inverse so a design that samples them late is caught.
    task access(input logic rd_en, input logic [7:0] code, input logic [31:0] data);
        @(posedge clk);
        #1;
        cmd_rd = rd_en;
        cmd_wr = !rd_en;
        cmd_code = code;
        cmd_wdata = data;
        @(posedge clk);
        #1;
        cmd_rd = 1'b0;
        cmd_wr = 1'b0;
        cmd_code = ~code;
        cmd_wdata = ~data;
    endtask : access
    task wr(input logic [7:0] code, input logic [31:0] data);
        access(1'b0, code, data);
    endtask : wr
    task rd(input logic [7:0] code, input logic [31:0] exp);
        exp_q.push_back(exp);
        access(1'b1, code, ~exp);
    endtask : rd
endmodule : uhsc_driver_model

// ==== uhsc_host_state.sv ====
// Host controller functional state, command/status register and frame start logic.
`timescale 1ns/1ps
`include "uhsc_map.svh"

// Functional notes
// - Entering operational from another state starts frame packets one millisecond later.
// - Frame start flag is set when each frame start packet is emitted.
// - Hardware changes the functional state only while it is suspend.
// - While suspended, downstream resume signaling moves the state to resume.
// - Hardware reset places the functional state in reset; software reset places it in suspend.
// - Hardware reset also resets the root hub and signals downstream port reset at the same time; port reset is held longer.
// - Command/status writes act only on bit 0: a one there sets it, zeros leave it unchanged.
// - All command/status bits read normally without side effects.
// - Command/status is read with code 02 and written with code 82.
// - Unfinished periodic list at frame end is a scheduling overrun.
// - Each overrun increments the counter and sets the overrun flag.
// - Overrun counter is read-only, bits 17 to 16, one step per overrun.
// - Overrun counter resets to zero and wraps from three to zero.
// - Counter increments even when the overrun flag is already set.
// - Overrun flag is event status bit 0, cleared by writing one or by a software or hardware reset.
// - Writing one to command bit 0 starts a software reset.
// - Software reset moves to suspend and clears the operational registers.
// - Reset command bit clears when software reset ends, within ten milliseconds.
// - Software reset leaves the root hub and downstream port reset alone.
module uhsc_host_state #(
    parameter int unsigned SOF_DELAY_CYCLES = `UHSC_SOF_DELAY_CYCLES,
    parameter int unsigned FRAME_CYCLES = `UHSC_FRAME_CYCLES,
    parameter int unsigned SOFT_RESET_CYCLES = `UHSC_SOFT_RESET_CYCLES,
    parameter int unsigned PORT_RESET_CYCLES = `UHSC_PORT_RESET_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_rd,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] cmd_wdata,
    output logic [31:0] cmd_rdata,
    output logic cmd_rvalid,
    input wire logic resume_pin,
    input wire logic periodic_busy,
    output logic [1:0] functional_state_field,
    output logic sof_pulse,
    output logic frame_end_pulse,
    output logic soft_reset_busy,
    output logic root_hub_reset,
    output logic port_reset
);

    localparam int CW = 32;

    if (SOF_DELAY_CYCLES < 1 || FRAME_CYCLES < 2 || SOFT_RESET_CYCLES < 1 || PORT_RESET_CYCLES < 1
        || SOFT_RESET_CYCLES > `UHSC_SOFT_RESET_LIMIT_CYCLES) begin : g_bad_timing
        $error("uhsc_host_state: timing counts out of range");
    end

    function automatic logic [CW-1:0] uhsc_dec(input logic [CW-1:0] v);
        uhsc_dec = (v == '0) ? '0 : v - 32'h0000_0001;
    endfunction : uhsc_dec

    function automatic logic [CW-1:0] uhsc_load(input int unsigned n);
        uhsc_load = CW'(n - 1);
    endfunction : uhsc_load

    ////////////////////////////////////////////////////////////////////////////////
    // Resume pin synchroniser and edge detect.

    logic resume_meta_q;
    logic resume_sync_q;
    logic resume_prev_q;
    logic resume_meta_d;
    logic resume_sync_d;
    logic resume_prev_d;
    logic resume_rise;

    always_comb begin
        resume_meta_d = resume_pin;
        resume_sync_d = resume_meta_q;
        resume_prev_d = resume_sync_q;
        resume_rise = resume_sync_q & ~resume_prev_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            resume_meta_q <= 1'b0;
            resume_sync_q <= 1'b0;
            resume_prev_q <= 1'b0;
        end else begin
            resume_meta_q <= resume_meta_d;
            resume_sync_q <= resume_sync_d;
            resume_prev_q <= resume_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.

    logic wr_ctrl;
    logic wr_cmdstat;
    logic wr_evstat;

    always_comb begin
        wr_ctrl = cmd_wr && (cmd_code == `UHSC_CODE_CTRL_WR);
        wr_cmdstat = cmd_wr && (cmd_code == `UHSC_CODE_CMDSTAT_WR);
        wr_evstat = cmd_wr && (cmd_code == `UHSC_CODE_EVSTAT_WR);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software reset sequencer.

    logic srst_q;
    logic srst_d;
    logic [CW-1:0] srst_cnt_q;
    logic [CW-1:0] srst_cnt_d;
    logic srst_start;
    logic srst_done;

    always_comb begin
        srst_start = wr_cmdstat && cmd_wdata[`UHSC_CMD_SOFT_RESET_BIT] && !srst_q;
        srst_done = srst_q && (srst_cnt_q == '0);
        srst_d = srst_q;
        srst_cnt_d = srst_cnt_q;
        if (srst_start) begin
            srst_d = 1'b1;
            srst_cnt_d = uhsc_load(SOFT_RESET_CYCLES);
        end else if (srst_done) begin
            srst_d = 1'b0;
        end else if (srst_q) begin
            srst_cnt_d = uhsc_dec(srst_cnt_q);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            srst_q <= 1'b0;
            srst_cnt_q <= '0;
        end else begin
            srst_q <= srst_d;
            srst_cnt_q <= srst_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Functional state.

    uhsc_pkg::uhsc_fstate_t fs_q;
    uhsc_pkg::uhsc_fstate_t fs_d;
    logic fs_enter_oper;

    always_comb begin
        fs_d = fs_q;
        if (srst_start) begin
            fs_d = uhsc_pkg::UHSC_FS_SUSPEND;
        end else if (wr_ctrl && !srst_q) begin
            fs_d = uhsc_pkg::uhsc_fstate_t'(cmd_wdata[`UHSC_CTRL_FS_MSB:`UHSC_CTRL_FS_LSB]);
        end else if (fs_q == uhsc_pkg::UHSC_FS_SUSPEND && resume_rise) begin
            fs_d = uhsc_pkg::UHSC_FS_RESUME;
        end
        fs_enter_oper = (fs_d == uhsc_pkg::UHSC_FS_OPER) && (fs_q != uhsc_pkg::UHSC_FS_OPER);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fs_q <= uhsc_pkg::UHSC_FS_RESET;
        end else begin
            fs_q <= fs_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame timing: one millisecond wait, then one start packet per frame.

    uhsc_pkg::uhsc_sof_t sof_st_q;
    uhsc_pkg::uhsc_sof_t sof_st_d;
    logic [CW-1:0] sof_cnt_q;
    logic [CW-1:0] sof_cnt_d;
    logic sof_pulse_q;
    logic sof_pulse_d;
    logic frame_end_q;
    logic frame_end_d;

    always_comb begin
        sof_st_d = sof_st_q;
        sof_cnt_d = uhsc_dec(sof_cnt_q);
        sof_pulse_d = 1'b0;
        frame_end_d = 1'b0;
        if (srst_start || srst_q || fs_d != uhsc_pkg::UHSC_FS_OPER) begin
            // Leaving operational stops frames at once; no partial frame is closed.
            sof_st_d = uhsc_pkg::UHSC_SOF_IDLE;
            sof_cnt_d = '0;
        end else if (fs_enter_oper) begin
            sof_st_d = uhsc_pkg::UHSC_SOF_WAIT;
            sof_cnt_d = uhsc_load(SOF_DELAY_CYCLES);
        end else begin
            unique case (sof_st_q)
                uhsc_pkg::UHSC_SOF_IDLE: begin
                    sof_cnt_d = '0;
                end
                uhsc_pkg::UHSC_SOF_WAIT: begin
                    if (sof_cnt_q == '0) begin
                        sof_st_d = uhsc_pkg::UHSC_SOF_RUN;
                        sof_pulse_d = 1'b1;
                        sof_cnt_d = uhsc_load(FRAME_CYCLES);
                    end
                end
                uhsc_pkg::UHSC_SOF_RUN: begin
                    if (sof_cnt_q == '0) begin
                        frame_end_d = 1'b1;
                        sof_pulse_d = 1'b1;
                        sof_cnt_d = uhsc_load(FRAME_CYCLES);
                    end
                end
                default: begin
                    sof_st_d = uhsc_pkg::UHSC_SOF_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sof_st_q <= uhsc_pkg::UHSC_SOF_IDLE;
            sof_cnt_q <= '0;
            sof_pulse_q <= 1'b0;
            frame_end_q <= 1'b0;
        end else begin
            sof_st_q <= sof_st_d;
            sof_cnt_q <= sof_cnt_d;
            sof_pulse_q <= sof_pulse_d;
            frame_end_q <= frame_end_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overrun counter and event status flags.

    logic overrun;
    logic [1:0] ovr_cnt_q;
    logic [1:0] ovr_cnt_d;
    logic ev_ovr_q;
    logic ev_ovr_d;
    logic ev_sof_q;
    logic ev_sof_d;

    always_comb begin
        // Sampled in the cycle the frame closes, alongside the next start packet.
        overrun = frame_end_d && periodic_busy;
        ovr_cnt_d = ovr_cnt_q;
        ev_ovr_d = ev_ovr_q;
        ev_sof_d = ev_sof_q;
        if (wr_evstat && cmd_wdata[`UHSC_EV_OVERRUN_BIT]) begin
            ev_ovr_d = 1'b0;
        end
        if (wr_evstat && cmd_wdata[`UHSC_EV_FRAME_START_BIT]) begin
            ev_sof_d = 1'b0;
        end
        if (overrun) begin
            ovr_cnt_d = ovr_cnt_q + 2'h1;
            ev_ovr_d = 1'b1;
        end
        if (sof_pulse_d) begin
            ev_sof_d = 1'b1;
        end
        if (srst_start || srst_q) begin
            ovr_cnt_d = `UHSC_OVR_CNT_RESET;
            ev_ovr_d = 1'b0;
            ev_sof_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_cnt_q <= `UHSC_OVR_CNT_RESET;
            ev_ovr_q <= 1'b0;
            ev_sof_q <= 1'b0;
        end else begin
            ovr_cnt_q <= ovr_cnt_d;
            ev_ovr_q <= ev_ovr_d;
            ev_sof_q <= ev_sof_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Root hub and downstream port reset after a hardware reset only.

    logic [CW-1:0] prst_cnt_q;
    logic [CW-1:0] prst_cnt_d;
    logic port_reset_q;
    logic port_reset_d;
    logic hub_reset_q;
    logic hub_reset_d;

    always_comb begin
        // Only the hardware reset loads these; the soft reset path never reaches them.
        hub_reset_d = 1'b0;
        port_reset_d = port_reset_q;
        prst_cnt_d = uhsc_dec(prst_cnt_q);
        if (port_reset_q && prst_cnt_q == '0) begin
            port_reset_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hub_reset_q <= 1'b1;
            port_reset_q <= 1'b1;
            prst_cnt_q <= uhsc_load(PORT_RESET_CYCLES);
        end else begin
            hub_reset_q <= hub_reset_d;
            port_reset_q <= port_reset_d;
            prst_cnt_q <= prst_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = cmd_rd;
        if (cmd_rd) begin
            rdata_d = `UHSC_RD_IDLE;
            unique case (cmd_code)
                `UHSC_CODE_CTRL_RD: begin
                    rdata_d[`UHSC_CTRL_FS_MSB:`UHSC_CTRL_FS_LSB] = fs_q;
                end
                `UHSC_CODE_CMDSTAT_RD: begin
                    rdata_d[`UHSC_CMD_OVR_CNT_MSB:`UHSC_CMD_OVR_CNT_LSB] = ovr_cnt_q;
                    rdata_d[`UHSC_CMD_SOFT_RESET_BIT] = srst_q;
                end
                `UHSC_CODE_EVSTAT_RD: begin
                    rdata_d[`UHSC_EV_OVERRUN_BIT] = ev_ovr_q;
                    rdata_d[`UHSC_EV_FRAME_START_BIT] = ev_sof_q;
                end
                default: begin
                    rdata_d = `UHSC_RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= `UHSC_RD_IDLE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    always_comb begin
        cmd_rdata = rdata_q;
        cmd_rvalid = rvalid_q;
        functional_state_field = fs_q;
        sof_pulse = sof_pulse_q;
        frame_end_pulse = frame_end_q;
        soft_reset_busy = srst_q;
        root_hub_reset = hub_reset_q;
        port_reset = port_reset_q;
    end

endmodule : uhsc_host_state

// ==== uhsc_host_state_properties.sv ====
// Port-level checker for the host state block.
`timescale 1ns/1ps
`include "uhsc_map.svh"
module uhsc_host_state_checker #(
    parameter int unsigned SOF_DELAY_CYCLES = 20,
    parameter int unsigned FRAME_CYCLES = 30,
    parameter int unsigned SOFT_RESET_CYCLES = 5,
    parameter int unsigned PORT_RESET_CYCLES = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_rd,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [31:0] cmd_wdata,
    input wire logic [31:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic resume_pin,
    input wire logic periodic_busy,
    input wire logic [1:0] functional_state_field,
    input wire logic sof_pulse,
    input wire logic frame_end_pulse,
    input wire logic soft_reset_busy,
    input wire logic root_hub_reset,
    input wire logic port_reset
);
    localparam int SD = SOF_DELAY_CYCLES;
    localparam int FR = FRAME_CYCLES;
    localparam int SRB = SOFT_RESET_CYCLES + 2;
    logic st_wr;
    // Any driver write that may legally move the state is excluded from the hold check.
    assign st_wr = cmd_wr && (cmd_code == `UHSC_CODE_CTRL_WR
        || (cmd_code == `UHSC_CODE_CMDSTAT_WR && cmd_wdata[0]));
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence soft_cmd;
        cmd_wr && cmd_code == `UHSC_CODE_CMDSTAT_WR && cmd_wdata[0] && !soft_reset_busy;
    endsequence
    sequence enter_oper;
        functional_state_field == 2'h2 && $past(functional_state_field) != 2'h2;
    endsequence
    ////////////////////////////////////////
    AST_READ_ANSWER: assert property (cmd_rd |=> cmd_rvalid)
        else $error("read not answered");
    AST_NO_STRAY: assert property (!cmd_rd |=> !cmd_rvalid)
        else $error("answer without read");
    AST_SOFT_START: assert property (soft_cmd |=> soft_reset_busy
        && functional_state_field == 2'h3)
        else $error("soft reset did not start");
    AST_SOFT_DONE: assert property ($rose(soft_reset_busy) |-> ##[1:SRB] !soft_reset_busy)
        else $error("soft reset too long");
    AST_PORT_QUIET: assert property (!port_reset |=> !port_reset)
        else $error("port reset outside hardware reset");
    AST_HW_RESET: assert property ($fell(rst) |-> functional_state_field == 2'h0
        && port_reset && root_hub_reset ##1 !root_hub_reset)
        else $error("hardware reset values wrong");
    AST_STATE_HOLD: assert property (functional_state_field != 2'h3 && !st_wr
        |=> $stable(functional_state_field))
        else $error("state moved by itself");
    AST_RESUME: assert property (functional_state_field == 2'h3 && $rose(resume_pin)
        && !soft_reset_busy |-> ##[1:6] functional_state_field == 2'h1)
        else $error("resume not taken");
    AST_SOF_START: assert property (enter_oper |-> ##SD sof_pulse)
        else $error("first frame start late");
    AST_FRAME_PERIOD: assert property (sof_pulse && functional_state_field == 2'h2
        |-> ##FR (sof_pulse || functional_state_field != 2'h2))
        else $error("frame period wrong");
    AST_FRAME_END: assert property (frame_end_pulse |-> sof_pulse)
        else $error("frame end apart from frame start");
endmodule : uhsc_host_state_checker

bind uhsc_host_state uhsc_host_state_checker #(.SOF_DELAY_CYCLES(SOF_DELAY_CYCLES),
    .FRAME_CYCLES(FRAME_CYCLES), .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES),
    .PORT_RESET_CYCLES(PORT_RESET_CYCLES)) i_uhsc_host_state_checker (.clk(clk), .rst(rst),
    .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .resume_pin(resume_pin),
    .periodic_busy(periodic_busy), .functional_state_field(functional_state_field),
    .sof_pulse(sof_pulse), .frame_end_pulse(frame_end_pulse),
    .soft_reset_busy(soft_reset_busy), .root_hub_reset(root_hub_reset),
    .port_reset(port_reset));

// ==== uhsc_map.svh ====
// Command codes, field positions, reset values and timing figures of the host state block.
`ifndef UHSC_MAP_SVH
`define UHSC_MAP_SVH

`define UHSC_CODE_CTRL_RD 8'h01
`define UHSC_CODE_CTRL_WR 8'h81
`define UHSC_CODE_CMDSTAT_RD 8'h02
`define UHSC_CODE_CMDSTAT_WR 8'h82
`define UHSC_CODE_EVSTAT_RD 8'h03
`define UHSC_CODE_EVSTAT_WR 8'h83

`define UHSC_CTRL_FS_LSB 6
`define UHSC_CTRL_FS_MSB 7
`define UHSC_CMD_SOFT_RESET_BIT 0
`define UHSC_CMD_OVR_CNT_LSB 16
`define UHSC_CMD_OVR_CNT_MSB 17
`define UHSC_EV_OVERRUN_BIT 0
`define UHSC_EV_FRAME_START_BIT 2

`define UHSC_OVR_CNT_RESET 2'h0
`define UHSC_RD_IDLE 32'h0000_0000

`define UHSC_CLK_MHZ 100
`define UHSC_SOF_DELAY_US 1000
`define UHSC_FRAME_US 1000
`define UHSC_SOFT_RESET_US 10
`define UHSC_SOFT_RESET_LIMIT_US 10000
`define UHSC_PORT_RESET_US 10
`define UHSC_SOF_DELAY_CYCLES (`UHSC_SOF_DELAY_US * `UHSC_CLK_MHZ)
`define UHSC_FRAME_CYCLES (`UHSC_FRAME_US * `UHSC_CLK_MHZ)
`define UHSC_SOFT_RESET_CYCLES (`UHSC_SOFT_RESET_US * `UHSC_CLK_MHZ)
`define UHSC_SOFT_RESET_LIMIT_CYCLES (`UHSC_SOFT_RESET_LIMIT_US * `UHSC_CLK_MHZ)
`define UHSC_PORT_RESET_CYCLES (`UHSC_PORT_RESET_US * `UHSC_CLK_MHZ)

`endif

// ==== uhsc_pkg.sv ====
// Types shared by the host state block.
package uhsc_pkg;

    // Default encoding order gives 00 reset, 01 resume, 10 operational, 11 suspend.
    typedef enum logic [1:0] {
        UHSC_FS_RESET,
        UHSC_FS_RESUME,
        UHSC_FS_OPER,
        UHSC_FS_SUSPEND
    } uhsc_fstate_t;

    typedef enum logic [1:0] {
        UHSC_SOF_IDLE,
        UHSC_SOF_WAIT,
        UHSC_SOF_RUN
    } uhsc_sof_t;

endpackage : uhsc_pkg

// ==== usb_host_state_and_command_status_bench.sv ====
// Self-checking bench for the host state block.
`timescale 1ns/1ps
`include "uhsc_map.svh"
module usb_host_state_and_command_status_bench;
    logic clk, rst, resume_pin, periodic_busy, cmd_rd, cmd_wr, cmd_rvalid;
    logic sof_pulse, frame_end_pulse, soft_reset_busy, root_hub_reset, port_reset;
    logic [7:0] cmd_code;
    logic [31:0] cmd_wdata, cmd_rdata, rnd;
    logic [1:0] fsf, cnt;
    int err_count, n_tests, i, n;
    integer seed;
    uhsc_host_state #(.SOF_DELAY_CYCLES(20), .FRAME_CYCLES(30), .SOFT_RESET_CYCLES(5),
        .PORT_RESET_CYCLES(5)) i_uhsc_host_state (.clk(clk), .rst(rst), .cmd_rd(cmd_rd),
        .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_rvalid(cmd_rvalid), .resume_pin(resume_pin), .periodic_busy(periodic_busy),
        .functional_state_field(fsf), .sof_pulse(sof_pulse),
        .frame_end_pulse(frame_end_pulse), .soft_reset_busy(soft_reset_busy),
        .root_hub_reset(root_hub_reset), .port_reset(port_reset));
    uhsc_driver_model i_uhsc_driver_model (.clk(clk), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    ////////////////////////////////////////
    task fail(input string msg);
        err_count++;
        $display("BAD %0t %s", $time, msg);
    endtask : fail
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
    endtask : check
    task wait_pulse(input logic fe);
        for (n = 0; n < 100 && (fe ? frame_end_pulse : sof_pulse) !== 1'b1; n++) begin
            @(posedge clk);
            #2;
        end
        if (n >= 100) fail("pulse missing");
    endtask : wait_pulse
    task complete_run;
        if (i_uhsc_driver_model.exp_q.size() != 0) err_count++;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial forever begin
        @(posedge clk);
        #2;
        if (cmd_rvalid === 1'b1) begin
            if (i_uhsc_driver_model.exp_q.size() == 0) fail("answer without read");
            else check(cmd_rdata, i_uhsc_driver_model.exp_q.pop_front());
        end
    end
    initial begin
        #100000;
        fail("watchdog expired");
        complete_run();
    end
    initial begin
        seed = 32'hc4318a4b;
        rst = 1'b1;
        resume_pin = 1'b0;
        periodic_busy = 1'b0;
        err_count = 0;
        n_tests = 0;
        cnt = 2'h0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        i_uhsc_driver_model.rd(`UHSC_CODE_CMDSTAT_RD, 32'h0);
        i_uhsc_driver_model.rd(`UHSC_CODE_CTRL_RD, 32'h0);
        i_uhsc_driver_model.rd(8'h05, 32'h0);
        rnd = $random(seed) & 32'hffff_fffe;
        i_uhsc_driver_model.wr(`UHSC_CODE_CMDSTAT_WR, rnd);
        i_uhsc_driver_model.rd(`UHSC_CODE_CMDSTAT_RD, 32'h0);
        i_uhsc_driver_model.wr(`UHSC_CODE_CTRL_WR, 32'h80);
        i_uhsc_driver_model.rd(`UHSC_CODE_EVSTAT_RD, 32'h0);
        i_uhsc_driver_model.rd(`UHSC_CODE_CTRL_RD, 32'h80);
        wait_pulse(1'b0);
        // Four forced overruns make the counter wrap whatever the random tail does.
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            #1 periodic_busy = (i < 4) ? 1'b1 : 1'(rnd[i]);
            wait_pulse(1'b1);
            cnt = cnt + 2'(periodic_busy);
        end
        @(posedge clk);
        #1 periodic_busy = 1'b0;
        i_uhsc_driver_model.rd(`UHSC_CODE_CMDSTAT_RD, {14'h0, cnt, 16'h0});
        i_uhsc_driver_model.rd(`UHSC_CODE_EVSTAT_RD, 32'h5);
        i_uhsc_driver_model.wr(`UHSC_CODE_EVSTAT_WR, 32'h1);
        i_uhsc_driver_model.rd(`UHSC_CODE_EVSTAT_RD, 32'h4);
        i_uhsc_driver_model.wr(`UHSC_CODE_CMDSTAT_WR, 32'h1);
        i_uhsc_driver_model.rd(`UHSC_CODE_CMDSTAT_RD, 32'h1);
        i_uhsc_driver_model.rd(`UHSC_CODE_CTRL_RD, 32'hc0);
        check({28'h0, fsf, root_hub_reset, port_reset}, 32'hc);
        // Busy is sampled after the edge has settled, never in the launching time step.
        for (n = 0; n < 20 && soft_reset_busy !== 1'b0; n++) begin
            @(posedge clk);
            #2;
        end
        check({31'h0, soft_reset_busy}, 32'h0);
        i_uhsc_driver_model.rd(`UHSC_CODE_CMDSTAT_RD, 32'h0);
        i_uhsc_driver_model.rd(`UHSC_CODE_EVSTAT_RD, 32'h0);
        @(posedge clk);
        #1 resume_pin = 1'b1;
        repeat (8) @(posedge clk);
        #1 resume_pin = 1'b0;
        i_uhsc_driver_model.rd(`UHSC_CODE_CTRL_RD, 32'h40);
        i_uhsc_driver_model.wr(`UHSC_CODE_CTRL_WR, 32'h80);
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        check({30'h0, root_hub_reset, port_reset}, 32'h3);
        i_uhsc_driver_model.rd(`UHSC_CODE_CTRL_RD, 32'h0);
        repeat (5) @(posedge clk);
        #2 check({30'h0, root_hub_reset, port_reset}, 32'h0);
        complete_run();
    end
endmodule : usb_host_state_and_command_status_bench
